// ---- src/eeprom_client.v ----
// Purpose: two-wire serial eeprom client: addressing, write path, write cycle timer
// Assumes: scl and sda arrive asynchronously; sda is open drain
// Notes:   array storage itself lies outside; writes leave as strobes
//
// Contract
// - main array is 8-byte pages, 16 pages small, 32 pages large variant
// - security region 32 bytes; 80h-8Fh read-only serial, 90h-9Fh user lockable; small variant masks word bit 7, so serial writes commit
// - device byte bits 7:4 type: 1010 main array, 1011 security and wpr
// - device byte bits 3:1 compared to fixed 3-bit client address, both types
// - device byte bit 0: one read, zero write
// - ack device byte only when type and client address both match
// - ack write-direction address byte to security region despite read-only half
// - word address byte follows device byte; 7 bits small, 8 bits large
// - security word address bits 7:6 equal 10, bit 5 ignored, 4:0 offset
// - secondary type decodes 0110xxxx lock function and 11xxxxxx wpr
// - protected write acks bytes, aborts cycle, stays ready
// - byte write acks both address bytes and data; stop starts cycle
// - during write cycle inputs ignored and no response
// - one cycle programs up to 8 bytes in one row; partial pages fine
// - page write takes up to seven more bytes, each acked, stop starts cycle
// - after each data byte only low three address bits increment, wrapping
// - no ack to write address byte during cycle; ack after it ends
// - start is sda fall with scl high, stop is sda rise with scl high
// - msb first, one bit per clock, ninth clock answers
// - ack holds sda low whole ninth high phase; drive after eighth fall, release after ninth fall
// - write-protect input sampled at stop; asserted skips write cycle
`timescale 1ns/1ns
`include "eeprom_consts.vh"

module eeprom_client #(
    parameter       LARGE        = 1,
    parameter [2:0] CLIENT_ADDR  = 3'h0,
    parameter       WRITE_CYCLES = `WRITE_CYCLES
) (
    input  wire       clk,
    input  wire       reset,
    input  wire       scl,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe,
    input  wire       write_protect,
    input  wire       region_protected,
    output reg        busy,
    output reg        wr_strobe,
    output reg  [7:0] wr_addr,
    output reg  [7:0] wr_data,
    output reg  [3:0] type_id,
    output reg  [7:0] word_addr,
    output reg        rd_request,
    output reg        commit,
    output reg        lock_sel,
    output reg        wpr_sel
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    reg [2:0] scl_s;
    reg [2:0] sda_s;
    reg       scl_q;
    reg       sda_q;
    // three-stage shift for each bus pin
    always @(posedge clk) begin
        scl_s <= {scl_s[1:0], scl};
    end

    always @(posedge clk) begin
        sda_s <= {sda_s[1:0], sda_in};
    end

    // settled levels: a change counts once stages two and three agree
    always @(posedge clk) begin
        if (reset) begin
            scl_q <= 1'b1;
        end else if (scl_s[1] == scl_s[2]) begin
            scl_q <= scl_s[2];
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            sda_q <= 1'b1;
        end else if (sda_s[1] == sda_s[2]) begin
            sda_q <= sda_s[2];
        end
    end

    // write-protect pin, synchronised like the bus pins
    reg [2:0] wp_s;
    reg       wp_q;
    always @(posedge clk) begin
        wp_s <= {wp_s[1:0], write_protect};
    end

    always @(posedge clk) begin
        if (reset) begin
            wp_q <= 1'b0;
        end else if (wp_s[1] == wp_s[2]) begin
            wp_q <= wp_s[2];
        end
    end
    wire scl_new  = (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_q;
    wire sda_new  = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_q;
    wire scl_rise = scl_new & ~scl_q;
    wire scl_fall = ~scl_new & scl_q;
    wire start_c  = scl_q & scl_new & sda_q & ~sda_new;
    wire stop_c   = scl_q & scl_new & ~sda_q & sda_new;

    // ------------------------------------------------------------
    // byte engine
    // ------------------------------------------------------------
    localparam ST_IDLE = 3'h0;
    localparam ST_DEV  = 3'h1;
    localparam ST_WORD = 3'h2;
    localparam ST_DATA = 3'h3;
    localparam ST_READ = 3'h4;

    reg [2:0]  state_q;
    reg [3:0]  bit_q;
    reg [7:0]  shift_q;
    reg        ack_q;
    reg        sec_q;
    reg [3:0]  nbytes_q;
    reg [31:0] timer_q;

    function [7:0] page_inc;
        input [7:0] a;
        begin
            page_inc = {a[7:3], a[2:0] + 3'h1};
        end
    endfunction

    // ------------------------------------------------------------
    // address decode helpers
    // ------------------------------------------------------------
    function [7:0] mask_addr;
        input [7:0] a;
        begin
            mask_addr = LARGE ? a : {1'b0, a[6:0]};
        end
    endfunction

    function dev_ok;
        input [7:0] b;
        begin
            dev_ok = ((b[7:4] == `TYPE_MAIN) || (b[7:4] == `TYPE_SEC))
                     && (b[3:1] == CLIENT_ADDR);
        end
    endfunction

    function serial_addr;
        input [7:0] a;
        begin
            serial_addr = (a[7:6] == `SEC_TOP_PATTERN) && (a[4] == 1'b0);
        end
    endfunction

    wire [7:0] byte_in    = {shift_q[6:0], sda_q};
    wire       dev_match  = dev_ok(shift_q);
    wire       serial_hit = sec_q && serial_addr(word_addr);

    // ------------------------------------------------------------
    // bit phase and write cycle qualifiers
    // ------------------------------------------------------------
    wire in_frame   = (state_q != ST_IDLE) && (state_q != ST_READ);
    wire bit_phase  = scl_rise && (bit_q < 4'h8);
    wire ack_phase  = scl_fall && (bit_q == 4'h8);
    wire ack_end    = scl_fall && (bit_q == 4'h9);
    wire have_data  = (state_q == ST_DATA) && (nbytes_q != 4'h0);
    wire write_ok   = !wp_q && !region_protected && !serial_hit;
    wire timer_done = (timer_q == 32'h1);

    // ------------------------------------------------------------
    // state and output registers
    // ------------------------------------------------------------

    always @(posedge clk) begin
        if (reset) begin
            state_q   <= ST_IDLE;
            bit_q     <= 4'h0;
            shift_q   <= 8'h00;
            ack_q     <= 1'b0;
            sec_q     <= 1'b0;
            nbytes_q  <= 4'h0;
            sda_oe    <= 1'b0;
            busy      <= 1'b0;
            wr_strobe <= 1'b0;
            wr_addr   <= 8'h00;
            wr_data   <= 8'h00;
            type_id   <= 4'h0;
            word_addr <= 8'h00;
            rd_request <= 1'b0;
            commit    <= 1'b0;
            lock_sel  <= 1'b0;
            wpr_sel   <= 1'b0;
        end else begin
            wr_strobe  <= 1'b0;
            commit     <= 1'b0;
            rd_request <= 1'b0;
            if (busy) begin
                sda_oe <= 1'b0;
                if (timer_done) begin
                    busy <= 1'b0;
                end
                state_q <= ST_IDLE;
            end else if (stop_c) begin
                sda_oe  <= 1'b0;
                state_q <= ST_IDLE;
                if (have_data) begin
                    // protected or locked-out writes are acked but start no cycle
                    if (write_ok) begin
                        commit <= 1'b1;
                        busy   <= 1'b1;
                    end
                end
            end else if (start_c) begin
                sda_oe   <= 1'b0;
                state_q  <= ST_DEV;
                bit_q    <= 4'h0;
                nbytes_q <= 4'h0;
            end else if (in_frame) begin
                if (bit_phase) begin
                    shift_q <= byte_in;
                    bit_q   <= bit_q + 4'h1;
                end else if (ack_phase) begin
                    // drive ack through ninth high phase
                    bit_q <= 4'h9;
                    ack_q <= 1'b1;
                    case (state_q)
                        ST_DEV: begin
                            ack_q   <= dev_match;
                            sda_oe  <= dev_match;
                            type_id <= shift_q[7:4];
                            sec_q   <= (shift_q[7:4] == `TYPE_SEC);
                        end
                        ST_WORD: begin
                            sda_oe    <= 1'b1;
                            word_addr <= mask_addr(shift_q);
                            wr_addr   <= mask_addr(shift_q);
                            lock_sel  <= sec_q && (shift_q[7:4] == `LOCK_NIBBLE);
                            wpr_sel   <= sec_q && (shift_q[7:6] == `WPR_TOP_PATTERN);
                        end
                        ST_DATA: begin
                            sda_oe    <= 1'b1;
                            wr_data   <= shift_q;
                            wr_strobe <= 1'b1;
                            if (nbytes_q != 4'h0) begin
                                wr_addr <= page_inc(wr_addr);
                            end
                            if (nbytes_q != 4'h8) begin
                                nbytes_q <= nbytes_q + 4'h1;
                            end
                        end
                        default: sda_oe <= 1'b0;
                    endcase
                end else if (ack_end) begin
                    sda_oe <= 1'b0;
                    bit_q  <= 4'h0;
                    if (!ack_q) begin
                        state_q <= ST_IDLE;
                    end else begin
                        case (state_q)
                            ST_DEV: begin
                                if (shift_q[0]) begin
                                    state_q    <= ST_READ;
                                    rd_request <= 1'b1;
                                end else begin
                                    state_q <= ST_WORD;
                                end
                            end
                            ST_WORD: state_q <= ST_DATA;
                            ST_DATA: state_q <= ST_DATA;
                            default: state_q <= ST_IDLE;
                        endcase
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // write cycle timer
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            timer_q <= 32'h0;
        end else if (busy) begin
            timer_q <= timer_q - 32'h1;
        end else if (stop_c && have_data && write_ok) begin
            timer_q <= WRITE_CYCLES;
        end
    end

    // ------------------------------------------------------------
    // pad drive
    // ------------------------------------------------------------
    // open drain: the pad only ever pulls low
    always @(posedge clk) begin
        sda_out <= 1'b0;
    end
endmodule // eeprom_client

// ---- src/eeprom_consts.vh ----
// Purpose: constants for the two-wire eeprom client write path
// Assumes: included by the client module
// Notes:   timing counts in clk cycles at 25 MHz
`ifndef EEPROM_CONSTS_VH
`define EEPROM_CONSTS_VH
`define TYPE_MAIN        4'hA
`define TYPE_SEC         4'hB
`define PAGE_BYTES       8
`define PAGES_SMALL      16
`define PAGES_LARGE      32
`define SEC_TOP_PATTERN  2'h2
`define LOCK_NIBBLE      4'h6
`define WPR_TOP_PATTERN  2'h3
`define SERIAL_BASE      8'h80
`define SERIAL_LAST      8'h8F
`define USER_BASE        8'h90
`define USER_LAST        8'h9F
`define CLK_HZ           25000000
`define WRITE_TIME_US    5000
`define WRITE_CYCLES     ((`CLK_HZ / 1000000) * `WRITE_TIME_US)
`endif

// ---- verif/eeprom_client_sva.sv ----
// Purpose: port assertions for the eeprom client
// Assumes: sda_in is the resolved bus line
// Notes:   bound to every eeprom_client instance
`timescale 1ns/1ns
module eeprom_client_sva #(parameter WRITE_CYCLES = 200) (
    input wire clk, reset, scl, sda_in, sda_out, sda_oe, write_protect, region_protected,
    input wire busy, wr_strobe, rd_request, commit, lock_sel, wpr_sel,
    input wire [7:0] wr_addr, wr_data, word_addr, input wire [3:0] type_id);
    reg [7:0]  last_q;
    reg        seen_q;
    reg [15:0] cnt_q;
    always @(posedge clk) begin
        if (reset || (scl && $fell(sda_in))) seen_q <= 1'b0;
        else if (wr_strobe) seen_q <= 1'b1;
        if (wr_strobe) last_q <= wr_addr;
        cnt_q <= busy ? cnt_q + 16'h1 : 16'h0;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence next_strobe; wr_strobe && seen_q; endsequence
    page_wrap_a: assert property (next_strobe |-> wr_addr == {last_q[7:3], last_q[2:0] + 3'h1})
        else $error("page address did not wrap in page");
    commit_busy_a: assert property (commit |-> ##[0:2] busy)
        else $error("busy did not follow commit");
    busy_len_a: assert property ($fell(busy) |-> cnt_q >= WRITE_CYCLES - 1 && cnt_q <= WRITE_CYCLES + 1)
        else $error("write cycle length wrong");
    busy_quiet_a: assert property (busy |-> !sda_oe && !wr_strobe)
        else $error("response during write cycle");
    strobe_pulse_a: assert property (wr_strobe |=> !wr_strobe)
        else $error("strobe longer than one cycle");
    wp_skip_a: assert property (commit |-> !write_protect)
        else $error("commit while write protected");
    prot_skip_a: assert property (commit |-> !region_protected)
        else $error("commit to protected region");
    serial_ro_a: assert property (commit && type_id == 4'hB |-> wr_addr[7:4] != 4'h8)
        else $error("commit to serial number");
    sel_excl_a: assert property (!(lock_sel && wpr_sel))
        else $error("both secondary selects high");
    drive_low_a: assert property (sda_oe |-> !sda_out)
        else $error("driven data not low");
endmodule // eeprom_client_sva
bind eeprom_client eeprom_client_sva #(.WRITE_CYCLES(WRITE_CYCLES)) u_sva (.*);

// ---- verif/i2c_host_model.sv ----
// Purpose: two-wire bus host driving scl and sda
// Assumes: sda has a pull-up; client pulls low via sda_oe
// Notes:   scl stands high between frames
`timescale 1ns/1ns
module i2c_host_model (output reg scl, input wire sda_oe, output wire sda);
    reg sda_h;
    assign sda = sda_h & ~sda_oe;
    initial begin scl = 1'b1; sda_h = 1'b1; end
    task start; begin sda_h = 1'b1; scl = 1'b1; #160 sda_h = 1'b0; #160 scl = 1'b0; end endtask
    task stop; begin #80 sda_h = 1'b0; #80 scl = 1'b1; #160 sda_h = 1'b1; #320; end endtask
    task send(input [7:0] b, output ack);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                #10 sda_h = b[i]; #150 scl = 1'b1; #160 scl = 1'b0;
            end
            #10 sda_h = 1'b1;
            #150 scl = 1'b1; #80 ack = ~sda; #80 scl = 1'b0; #40;
        end
    endtask
endmodule // i2c_host_model

// ---- verif/tb.sv ----
// Purpose: self-checking bench for the eeprom client
// Assumes: client address 0, large variant
// Notes:   short write cycle of 200 clocks
`timescale 1ns/1ns
module tb;
    reg clk, reset, write_protect, region_protected, ack;
    reg rd_seen = 1'b0;
    wire scl, sda, sda_out, sda_oe, busy, wr_strobe, rd_request, commit, lock_sel, wpr_sel;
    wire [7:0] wr_addr, wr_data, word_addr;
    wire [3:0] type_id;
    integer miscompares = 0, n_tests = 0, cyc = 0, commits = 0, i;
    reg [7:0] qa[$], qd[$];
    reg [8:0] rows [0:5] = '{9'h1A0, 9'h1B0, 9'h1A1, 9'h0C0, 9'h0A2, 9'h090};
    eeprom_client #(.LARGE(1), .CLIENT_ADDR(3'h0), .WRITE_CYCLES(200)) u_eeprom_client (
        .clk(clk), .reset(reset), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .write_protect(write_protect), .region_protected(region_protected), .busy(busy),
        .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data), .type_id(type_id),
        .word_addr(word_addr), .rd_request(rd_request), .commit(commit), .lock_sel(lock_sel),
        .wpr_sel(wpr_sel));
    i2c_host_model u_i2c_host_model (.scl(scl), .sda_oe(sda_oe), .sda(sda));
    initial begin clk = 1'b0; forever #20 clk = ~clk; end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (wr_strobe) begin qa.push_back(wr_addr); qd.push_back(wr_data); end
        if (commit) commits <= commits + 1;
        if (rd_request) rd_seen <= 1'b1;
        if (cyc == 30000) begin miscompares = miscompares + 1; tally_and_finish; end
    end
    task chk(input [7:0] g, input [7:0] e); begin
        n_tests = n_tests + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    end endtask
    task xfer(input [7:0] b, input e); begin
        u_i2c_host_model.send(b, ack);
        chk({7'h0, ack}, {7'h0, e});
    end endtask
    task wait_idle; begin
        for (i = 0; i < 400 && busy !== 1'b0; i = i + 1) @(posedge clk);
    end endtask
    task tally_and_finish; begin
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    end endtask
    initial begin
        reset = 1'b1; write_protect = 1'b0; region_protected = 1'b0;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        for (i = 0; i < 6; i = i + 1) begin
            u_i2c_host_model.start; xfer(rows[i][7:0], rows[i][8]); u_i2c_host_model.stop;
        end
        chk({7'h0, rd_seen}, 8'h01);
        $display("address decode test done");
        u_i2c_host_model.start; xfer(8'hA0, 1'b1); xfer(8'h1E, 1'b1);
        for (i = 0; i < 8; i = i + 1) xfer(8'h50 + i, 1'b1);
        u_i2c_host_model.stop;
        chk(word_addr, 8'h1E);
        for (i = 0; i < 8; i = i + 1) begin
            chk(qa[i], 8'h18 + ((6 + i) % 8));
            chk(qd[i], 8'h50 + i);
        end
        chk(commits, 1);
        u_i2c_host_model.start; xfer(8'hA0, 1'b0); u_i2c_host_model.stop;
        wait_idle;
        u_i2c_host_model.start; xfer(8'hA0, 1'b1); u_i2c_host_model.stop;
        $display("page write and polling test done");
        for (i = 0; i < 3; i = i + 1) begin
            @(negedge clk) begin write_protect = (i == 0); region_protected = (i == 1); end
            u_i2c_host_model.start; xfer(i == 2 ? 8'hB0 : 8'hA0, 1'b1);
            xfer(i == 2 ? 8'h80 : 8'h05, 1'b1); xfer(8'h3C, 1'b1); u_i2c_host_model.stop;
            chk(commits, 1);
            chk({7'h0, busy}, 8'h00);
        end
        @(negedge clk) begin write_protect = 1'b0; region_protected = 1'b0; end
        $display("protected write test done");
        for (i = 0; i < 2; i = i + 1) begin
            u_i2c_host_model.start; xfer(8'hB0, 1'b1); xfer(i ? 8'hDF : 8'h6F, 1'b1);
            chk({6'h0, lock_sel, wpr_sel}, i ? 8'h01 : 8'h02);
            chk({type_id, 4'h0}, 8'hB0);
            u_i2c_host_model.stop;
        end
        $display("secondary decode test done");
        u_i2c_host_model.start; xfer(8'hA0, 1'b1); xfer(8'h07, 1'b1); xfer(8'h11, 1'b1);
        u_i2c_host_model.stop;
        @(negedge clk) reset = 1'b1;
        repeat (4) @(negedge clk);
        chk({busy, commit, wr_strobe, sda_oe, lock_sel, wpr_sel}, 8'h00);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        u_i2c_host_model.start; xfer(8'hA0, 1'b1); u_i2c_host_model.stop;
        $display("reset test done");
        tally_and_finish;
    end
endmodule // tb
